// ==== src/umf_pkg.sv ====
// Constants, types and state layout for the multidrop UART block.
// Rules for this block and its remote side
// RL1: Receiver runs only while receive enable is set.
// RL2: Byte-available flag is 1 while the receive register holds a byte.
// RL3: Separate error, break and data status flags identify the interrupt cause.
// RL4: Option selects receiver interrupt on data and errors, or errors only.
// RL5: Clear-to-send flow control acts only when its enable is set.
// RL6: Clear-to-send is sampled one clock before each character starts.
// RL7: A character already started is always finished.
// RL8: Remote side deasserts clear-to-send at least one clock before a character.
// RL9: Multidrop flag bit sits after eight data bits, before stop bits.
// RL10: In multidrop mode the ninth bit is the flag, not parity.
// RL11: Every address filter needs multidrop enable set.
// RL12: Filter 01: address bytes interrupt, data bytes never.
// RL13: Filter 00: every byte interrupts; a status bit marks address bytes.
// RL14: Filter 10: compare address; drop mismatched address and its data.
// RL15: Filter 10: matching address and its data bytes all interrupt.
// RL16: First data byte of a matched frame carries the new-frame bit.
// RL17: Every new address is compared again; mismatch drops bytes until match.
// RL18: Filter 11: like 10 but address bytes give no interrupt.
// RL19: Driver enable rises on a transmit write and covers the whole frame.
// RL20: Driver enable leads the start bit by one to two bit periods; the code gives 15 to 16 ticks plus two clocks.
// RL21: Driver enable falls one clock after last stop; held for back-to-back.
// RL22: A polarity input selects driver enable active high or low.
// RL23: Eight data bits LSB first, low start, one or two stops, parity.
// RL24: Reading the receive data clears the byte-available flag.
// RL25: Eight-bit address compare value checked against address characters.
package umf_pkg;
   // Sixteen baud ticks per bit
   localparam logic [3:0] OS_LAST = 4'hF;
   localparam logic [3:0] OS_MID = 4'h7;
   localparam logic [3:0] OS_ZERO = 4'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [15:0] DIV_ONE = 16'h0001;
   localparam logic [15:0] DIV_ZERO = 16'h0000;
   localparam int BUF_DEPTH = 2;
   localparam int BUF_AW = 1;
   localparam int DATA_W = 8;
   localparam logic [1:0] BUF_FULL = 2'h2;
   localparam logic [1:0] BUF_EMPTY = 2'h0;
   localparam logic [1:0] FILT_ANY = 2'h0;
   localparam logic [1:0] FILT_ADDR = 2'h1;
   localparam logic [1:0] FILT_HW = 2'h2;
   localparam logic [1:0] FILT_HW_QUIET = 2'h3;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_NINTH = 3'b011,
      RX_STOP = 3'b100,
      RX_BRK = 3'b101
   } umf_rx_st_t;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_LEAD = 3'b001,
      TX_CTS = 3'b010,
      TX_START = 3'b011,
      TX_DATA = 3'b100,
      TX_NINTH = 3'b101,
      TX_STOP = 3'b110,
      TX_TAIL = 3'b111
   } umf_tx_st_t;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic rx_byte_available;
      logic rx_addr_flag;
      logic frame_first_byte;
      logic parity_err;
      logic overrun_err;
      logic framing_err;
      logic break_det;
   } umf_rx_stat_t;

   typedef struct packed {
      logic [15:0] div_cnt;
      umf_rx_st_t rx_st;
      logic [3:0] rx_os;
      logic [2:0] rx_bit;
      logic [DATA_W-1:0] rx_sh;
      logic rx_ninth;
      logic matched;
      logic pend_first;
      umf_rx_stat_t stat;
      umf_tx_st_t tx_st;
      logic [3:0] tx_os;
      logic [2:0] tx_bit;
      logic [DATA_W-1:0] tx_sh;
      logic tx_ninth;
      logic tx_second_stop;
      logic txd;
      logic de;
      logic [BUF_DEPTH-1:0][DATA_W:0] buf_mem;
      logic [BUF_AW-1:0] wr;
      logic [BUF_AW-1:0] rd;
      logic [1:0] cnt;
   } umf_state_t;
endpackage

// ==== src/umf_uart.sv ====
// Multidrop UART with address filtering, flow control and driver enable.
`timescale 1ns/10ps
module umf_uart (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [15:0] i_baud_div,
   input wire logic i_rx_en,
   input wire logic i_tx_en,
   input wire logic i_parity_en,
   input wire logic i_parity_odd,
   input wire logic i_two_stop,
   input wire logic i_flow_ctl_enable,
   input wire logic i_multidrop_enable,
   input wire logic [1:0] i_addr_filter_select,
   input wire logic [7:0] i_addr_compare,
   input wire logic i_rx_data_irq_en,
   input wire logic i_drive_en_active_low,
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   input wire logic i_tx_addr_bit,
   output logic o_tx_ready,
   input wire logic i_rx_read,
   output umf_pkg::umf_rx_stat_t o_rx_stat,
   output logic o_rx_irq,
   input wire logic i_rxd,
   output logic o_txd,
   input wire logic i_cts_n,
   output logic o_xcvr_drive_en
);
   import umf_pkg::*;

   umf_state_t s;
   umf_state_t n;
   logic tick;
   logic ninth_on;
   logic char_done;
   logic is_addr;
   logic hit;
   logic keep;
   logic first;
   logic brk;
   logic fe;
   logic push;
   logic pop;
   logic cts_ok;
   logic end_char;
   logic tx_more;

   // Bit value that makes the nine-bit group even, or odd when asked
   function automatic logic par8(input logic [7:0] d, input logic odd);
      par8 = (^d) ^ odd;
   endfunction

   assign o_tx_ready = (s.cnt != BUF_FULL);
   assign o_rx_stat = s.stat;
   assign o_txd = s.txd;
   assign o_xcvr_drive_en = s.de ^ i_drive_en_active_low; // see RL22
   // Error flags always interrupt; data only when enabled
   assign o_rx_irq = (s.stat.rx_byte_available & i_rx_data_irq_en) |
      s.stat.parity_err | s.stat.overrun_err |
      s.stat.framing_err | s.stat.break_det; // see RL3, see RL4

   always_comb begin
      n = s;
      char_done = 1'b0;
      keep = 1'b0;
      first = 1'b0;
      pop = 1'b0;
      end_char = 1'b0;
      push = i_tx_valid & o_tx_ready;
      ninth_on = i_multidrop_enable | i_parity_en;
      tx_more = (s.cnt != BUF_EMPTY) & i_tx_en;
      cts_ok = ~i_flow_ctl_enable | ~i_cts_n; // see RL5
      is_addr = i_multidrop_enable & s.rx_ninth;
      hit = (s.rx_sh == i_addr_compare); // see RL25
      fe = ~i_rxd;
      brk = fe & (s.rx_sh == 8'h00) & ~s.rx_ninth;

      // Shared baud tick; a zero divisor behaves like one
      tick = (s.div_cnt == DIV_ZERO);
      if (tick) begin
         if (i_baud_div == DIV_ZERO) begin
            n.div_cnt = DIV_ZERO;
         end else begin
            n.div_cnt = i_baud_div - DIV_ONE;
         end
      end else begin
         n.div_cnt = s.div_cnt - DIV_ONE;
      end

      // Receiver
      if (!i_rx_en) begin
         n.rx_st = RX_IDLE; // see RL1
      end else begin
         unique case (s.rx_st)
            RX_IDLE: begin
               if (!i_rxd) begin
                  n.rx_st = RX_START;
                  n.rx_os = OS_ZERO;
               end
            end
            RX_START: begin
               if (tick) begin
                  n.rx_os = s.rx_os + 4'h1;
                  // Glitch shorter than half a bit is not a start
                  if (s.rx_os == OS_MID) begin
                     n.rx_os = OS_ZERO;
                     n.rx_bit = 3'h0;
                     n.rx_ninth = 1'b0;
                     n.rx_st = i_rxd ? RX_IDLE : RX_DATA;
                  end
               end
            end
            RX_DATA: begin
               if (tick) begin
                  n.rx_os = s.rx_os + 4'h1;
                  if (s.rx_os == OS_LAST) begin
                     n.rx_sh = {i_rxd, s.rx_sh[7:1]}; // see RL23
                     n.rx_bit = s.rx_bit + 3'h1;
                     if (s.rx_bit == BIT_LAST) begin
                        n.rx_st = ninth_on ? RX_NINTH : RX_STOP; // see RL9
                     end
                  end
               end
            end
            RX_NINTH: begin
               if (tick) begin
                  n.rx_os = s.rx_os + 4'h1;
                  if (s.rx_os == OS_LAST) begin
                     n.rx_ninth = i_rxd;
                     n.rx_st = RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (tick) begin
                  n.rx_os = s.rx_os + 4'h1;
                  if (s.rx_os == OS_LAST) begin
                     char_done = 1'b1;
                     // A held-low line must go high before a new start
                     n.rx_st = i_rxd ? RX_IDLE : RX_BRK;
                  end
               end
            end
            RX_BRK: begin
               if (i_rxd) begin
                  n.rx_st = RX_IDLE;
               end
            end
            default: begin
               n.rx_st = RX_IDLE;
            end
         endcase
      end

      // Address filtering of a finished character
      if (char_done) begin
         if (!i_multidrop_enable) begin
            keep = 1'b1; // see RL11
         end else begin
            unique case (i_addr_filter_select)
               FILT_ANY: begin
                  keep = 1'b1; // see RL13
               end
               FILT_ADDR: begin
                  keep = is_addr; // see RL12
               end
               FILT_HW, FILT_HW_QUIET: begin
                  if (is_addr) begin
                     // Each address is judged afresh
                     n.matched = hit; // see RL14, see RL17
                     n.pend_first = hit;
                     keep = hit & (i_addr_filter_select == FILT_HW); // see RL15, see RL18
                  end else begin
                     keep = s.matched; // see RL14, see RL15
                     first = s.pend_first; // see RL16
                     if (s.matched) begin
                        n.pend_first = 1'b0;
                     end
                  end
               end
            endcase
         end
      end

      // Read clears first; a byte landing in the same cycle wins
      if (i_rx_read) begin
         n.stat.rx_byte_available = 1'b0; // see RL24
         n.stat.parity_err = 1'b0;
         n.stat.overrun_err = 1'b0;
         n.stat.framing_err = 1'b0;
         n.stat.break_det = 1'b0;
      end
      if (char_done & (keep | brk)) begin
         if (s.stat.rx_byte_available & ~i_rx_read) begin
            // Unread byte is kept; only the overrun is noted
            n.stat.overrun_err = 1'b1;
         end else begin
            n.stat.data = s.rx_sh;
            n.stat.rx_byte_available = 1'b1; // see RL2
            n.stat.rx_addr_flag = is_addr; // see RL13
            n.stat.frame_first_byte = first; // see RL16
            n.stat.parity_err = i_parity_en & ~i_multidrop_enable &
               (s.rx_ninth != par8(s.rx_sh, i_parity_odd)); // see RL10
            n.stat.framing_err = fe;
            n.stat.break_det = brk;
         end
      end

      // Transmitter
      unique case (s.tx_st)
         TX_IDLE: begin
            if (tx_more) begin
               n.de = 1'b1; // see RL19
               n.tx_os = OS_ZERO;
               n.tx_st = TX_LEAD;
            end
         end
         TX_LEAD: begin
            // Sixteen ticks counting the partial first: 15 to 16 ticks plus two clocks, about one bit
            if (tick) begin
               n.tx_os = s.tx_os + 4'h1;
               if (s.tx_os == OS_LAST) begin
                  n.tx_st = TX_CTS; // see RL20
               end
            end
         end
         TX_CTS: begin
            // Registered start: the pin is seen one clock ahead
            if (cts_ok) begin
               pop = 1'b1; // see RL6
               n.tx_sh = s.buf_mem[s.rd][7:0];
               if (i_multidrop_enable) begin
                  n.tx_ninth = s.buf_mem[s.rd][8]; // see RL10
               end else begin
                  n.tx_ninth = par8(s.buf_mem[s.rd][7:0], i_parity_odd);
               end
               n.txd = 1'b0;
               n.tx_os = OS_ZERO;
               n.tx_st = TX_START;
            end
         end
         TX_START: begin
            if (tick) begin
               n.tx_os = s.tx_os + 4'h1;
               if (s.tx_os == OS_LAST) begin
                  n.txd = s.tx_sh[0]; // see RL23
                  n.tx_bit = 3'h0;
                  n.tx_st = TX_DATA;
               end
            end
         end
         TX_DATA: begin
            // Flow control is not looked at here, so a started
            // character always runs to its end
            if (tick) begin
               n.tx_os = s.tx_os + 4'h1;
               if (s.tx_os == OS_LAST) begin
                  n.tx_bit = s.tx_bit + 3'h1;
                  n.tx_sh = {1'b0, s.tx_sh[7:1]};
                  n.txd = s.tx_sh[1];
                  if (s.tx_bit == BIT_LAST) begin
                     n.tx_second_stop = i_two_stop;
                     if (ninth_on) begin
                        n.txd = s.tx_ninth; // see RL9
                        n.tx_st = TX_NINTH;
                     end else begin
                        n.txd = 1'b1;
                        n.tx_st = TX_STOP; // see RL7
                     end
                  end
               end
            end
         end
         TX_NINTH: begin
            if (tick) begin
               n.tx_os = s.tx_os + 4'h1;
               if (s.tx_os == OS_LAST) begin
                  n.txd = 1'b1;
                  n.tx_st = TX_STOP;
               end
            end
         end
         TX_STOP: begin
            if (tick) begin
               n.tx_os = s.tx_os + 4'h1;
               if (s.tx_os == OS_LAST) begin
                  if (s.tx_second_stop) begin
                     n.tx_second_stop = 1'b0;
                  end else begin
                     end_char = 1'b1;
                  end
               end
            end
         end
         TX_TAIL: begin
            n.de = 1'b0; // see RL21
            n.tx_st = TX_IDLE;
         end
      endcase
      if (end_char) begin
         // Next byte already waiting: keep the driver on
         n.tx_st = tx_more ? TX_CTS : TX_TAIL; // see RL21
      end

      // Two-entry transmit buffer
      if (push) begin
         n.buf_mem[s.wr] = {i_tx_addr_bit, i_tx_data};
         n.wr = s.wr + 1'b1;
      end
      if (pop) begin
         n.rd = s.rd + 1'b1;
      end
      if (push & ~pop) begin
         n.cnt = s.cnt + 2'h1;
      end else if (pop & ~push) begin
         n.cnt = s.cnt - 2'h1;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s <= '0;
         s.txd <= 1'b1;
      end else begin
         s <= n;
      end
   end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the multidrop UART.
`timescale 1ns/10ps
module tb;
   import umf_pkg::*;
   logic clk, nrst, rx_en, fc, mp, irq_en, pol, tx_v, tx_a, rd, a, h;
   logic tx_rdy, irq, txd, rxd, cts_n, de_pin;
   logic pen, podd, two_st, p;
   logic [1:0] filt;
   logic [7:0] adr, tx_d, d;
   logic [8:0] r;
   logic [8:0] q[$];
   umf_rx_stat_t st;
   int failures = 0;
   int num_checks = 0;
   logic [31:0] lf = 32'he7db;

   umf_uart i_umf_uart (.i_clk(clk), .i_nrst(nrst),
      .i_baud_div(16'h0001), .i_rx_en(rx_en), .i_tx_en(1'b1),
      .i_parity_en(pen), .i_parity_odd(podd), .i_two_stop(two_st),
      .i_flow_ctl_enable(fc), .i_multidrop_enable(mp),
      .i_addr_filter_select(filt), .i_addr_compare(adr),
      .i_rx_data_irq_en(irq_en), .i_drive_en_active_low(pol),
      .i_tx_valid(tx_v), .i_tx_data(tx_d), .i_tx_addr_bit(tx_a),
      .o_tx_ready(tx_rdy), .i_rx_read(rd), .o_rx_stat(st),
      .o_rx_irq(irq), .i_rxd(rxd), .o_txd(txd), .i_cts_n(cts_n),
      .o_xcvr_drive_en(de_pin));
   umf_remote i_umf_remote (.i_clk(clk), .i_txd(txd), .o_rxd(rxd),
      .o_cts_n(cts_n));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Ninth bit that makes the group even, or odd when asked
   function automatic logic par(input logic [7:0] v, input logic o);
      return (^v) ^ o;
   endfunction
   function automatic logic keep(input int m, input logic a, input logic h);
      case (m)
         1: return a;
         2: return h;
         3: return h && !a;
         default: return 1'b1;
      endcase
   endfunction
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic rdb;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      chk(9'(st.rx_byte_available), 9'h000);
   endtask
   task automatic rxc(input logic [8:0] c, input logic e);
      i_umf_remote.send(c, mp, 1'b1);
      chk(9'(st.rx_byte_available), 9'(e));
      if (e) begin
         chk(9'(st.data), 9'(c[7:0]));
         chk(9'(irq), 9'(irq_en));
      end else begin
         chk(9'(irq), 9'h000);
      end
   endtask
   task automatic wrb(input logic [8:0] c);
      {tx_a, tx_d} = c;
      tx_v = 1'b1;
      @(negedge clk);
      tx_v = 1'b0;
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (30000) @(posedge clk);
      failures++;
      test_done;
   end

   initial begin
      {nrst, rx_en, fc, mp, pol, tx_v, tx_a, rd, tx_d} = '0;
      {pen, podd, two_st} = '0;
      irq_en = 1'b1;
      filt = 2'h0;
      adr = lf[7:0];
      cyc(12);
      nrst = 1'b1;
      rx_en = 1'b1;
      chk(9'({txd, irq, st.rx_byte_available, tx_rdy, de_pin}), 9'h012);
      for (int m = 0; m < 5; m++) begin
         mp = m < 4;
         filt = m == 4 ? 2'h2 : 2'(m);
         h = 1'b0;
         // Fresh station address for every filter mode
         lf = lfsr(lf);
         adr = lf[7:0];
         for (int k = 0; k < 5; k++) begin
            a = k == 0 || k == 3;
            lf = lfsr(lf);
            d = k == 0 ? adr : k == 3 ? ~adr : lf[7:0];
            if (a) h = k == 0;
            rxc({a, d}, keep(m, a, h));
            if (m == 0) chk(9'(st.rx_addr_flag), 9'(a));
            if (m inside {2, 3} && k < 3 && !a)
               chk(9'(st.frame_first_byte), 9'(k == 1));
            if (keep(m, a, h)) rdb;
         end
      end
      $display("multidrop receive done");
      mp = 1'b0;
      irq_en = 1'b0;
      rxc(9'h05a, 1'b1);
      rdb;
      i_umf_remote.send(9'h0a5, 1'b0, 1'b0);
      chk(9'({st.framing_err, irq}), 9'h003);
      rdb;
      irq_en = 1'b1;
      rx_en = 1'b0;
      rxc(9'h0ff, 1'b0);
      rx_en = 1'b1;
      pen = 1'b1;
      lf = lfsr(lf);
      podd = lf[9];
      d = lf[7:0];
      p = par(d, podd);
      i_umf_remote.send({p, d}, 1'b1, 1'b1);
      chk({st.parity_err, st.data}, {1'b0, d});
      rdb;
      i_umf_remote.send({~p, d}, 1'b1, 1'b1);
      chk({st.parity_err, st.data}, {1'b1, d});
      rdb;
      // Two stops: driver must still be on a bit after the first stop
      two_st = 1'b1;
      wrb({1'b0, d});
      i_umf_remote.get(1'b1, r);
      chk(r, {p, d});
      cyc(16);
      chk(9'({txd, de_pin}), 9'h003);
      cyc(20);
      chk(9'(de_pin), 9'h000);
      {pen, two_st} = '0;
      $display("error and enable receive done");
      mp = 1'b1;
      i_umf_remote.set_cts(1'b1);
      lf = lfsr(lf);
      wrb(lf[8:0]);
      i_umf_remote.get(1'b1, r);
      chk(r, lf[8:0]);
      fc = 1'b1;
      tx_v = 1'b1;
      while (tx_rdy === 1'b1 && q.size() < 4) begin
         lf = lfsr(lf);
         {tx_a, tx_d} = lf[8:0];
         q.push_back(lf[8:0]);
         @(negedge clk);
      end
      tx_v = 1'b0;
      chk(9'(tx_rdy), 9'h000);
      cyc(100);
      chk(9'({txd, de_pin}), 9'h003);
      i_umf_remote.set_cts(1'b0);
      fork
         foreach (q[i]) begin
            i_umf_remote.get(1'b1, r);
            chk(r, q[i]);
         end
         begin
            cyc(60);
            i_umf_remote.set_cts(1'b1);
            cyc(300);
            i_umf_remote.set_cts(1'b0);
         end
      join
      cyc(20);
      chk(9'(de_pin), 9'h000);
      $display("transmit flow control done");
      nrst = 1'b0;
      pol = 1'b1;
      fc = 1'b0;
      cyc(2);
      chk(9'(de_pin), 9'h001);
      nrst = 1'b1;
      lf = lfsr(lf);
      wrb(lf[8:0]);
      cyc(4);
      chk(9'(de_pin), 9'h000);
      i_umf_remote.get(1'b1, r);
      chk(r, lf[8:0]);
      $display("polarity done");
      test_done;
   end
endmodule

bind umf_uart umf_uart_chk i_chk (.i_clk, .i_nrst, .i_rx_en,
   .i_flow_ctl_enable, .i_rx_data_irq_en, .i_drive_en_active_low,
   .i_rx_read, .o_rx_stat, .o_rx_irq, .o_txd, .o_xcvr_drive_en);

// ==== testbench/umf_remote.sv ====
// Remote bus node: sends frames, receives frames, drives clear-to-send.
`timescale 1ns/10ps
module umf_remote (
   input wire logic i_clk,
   input wire logic i_txd,
   output logic o_rxd,
   output logic o_cts_n
);
   initial begin
      o_rxd = 1'b1;
      o_cts_n = 1'b0;
   end
   task automatic bit_out(input logic b);
      o_rxd = b;
      repeat (16) @(negedge i_clk);
   endtask
   task automatic send(input logic [8:0] c, input logic nb, input logic s);
      bit_out(1'b0);
      for (int i = 0; i < 8; i++) bit_out(c[i]);
      if (nb) bit_out(c[8]);
      bit_out(s);
      // Pulled-up line rests high between frames
      bit_out(1'b1);
   endtask
   // Called only at a falling edge, ahead of the next start
   task automatic set_cts(input logic v);
      o_cts_n = v;
   endtask
   task automatic get(input logic nb, output logic [8:0] c);
      int n = 0;
      c = 9'h000;
      while (i_txd !== 1'b0 && n < 3000) begin
         @(negedge i_clk);
         n++;
      end
      repeat (8) @(negedge i_clk);
      for (int i = 0; i < 9; i++) begin
         if (i < 8 || nb) begin
            repeat (16) @(negedge i_clk);
            c[i] = i_txd;
         end
      end
      // Return mid stop bit so a low ninth bit is not seen as a start
      repeat (16) @(negedge i_clk);
   endtask
endmodule

// ==== testbench/umf_uart_assertions.sv ====
// Port-level timing checks for the multidrop UART.
`timescale 1ns/10ps
module umf_uart_chk (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_rx_en,
   input wire logic i_flow_ctl_enable,
   input wire logic i_rx_data_irq_en,
   input wire logic i_drive_en_active_low,
   input wire logic i_rx_read,
   input wire umf_pkg::umf_rx_stat_t o_rx_stat,
   input wire logic o_rx_irq,
   input wire logic o_txd,
   input wire logic o_xcvr_drive_en
);
   import umf_pkg::*;
   // Checks assume a divisor of one, sixteen clocks a bit
   wire logic de = o_xcvr_drive_en ^ i_drive_en_active_low;
   wire logic av = o_rx_stat.rx_byte_available;
   wire logic er = o_rx_stat.parity_err | o_rx_stat.overrun_err |
      o_rx_stat.framing_err | o_rx_stat.break_det;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   rx_off_a:
      assert property (!i_rx_en |=> !$rose(av))
      else $error("byte stored while receiver off");
   read_clr_a:
      assert property (i_rx_read |=> !av || $changed(o_rx_stat.data))
      else $error("read left byte flag set");
   irq_data_a:
      assert property (i_rx_data_irq_en && av |-> o_rx_irq)
      else $error("stored byte without interrupt");
   irq_err_only_a:
      assert property (!i_rx_data_irq_en && !er |-> !o_rx_irq)
      else $error("data interrupt in errors-only mode");
   first_data_a:
      assert property ($rose(o_rx_stat.frame_first_byte) |->
         av && !o_rx_stat.rx_addr_flag)
      else $error("new-frame bit on a non data byte");
   de_idle_a:
      assert property (!de |-> o_txd)
      else $error("line driven low without driver enable");
   de_lead_a:
      assert property ($rose(de) |-> o_txd[*8] ##1 o_txd[*8])
      else $error("driver enable lead below one bit");
   de_max_a:
      assert property ($rose(de) && !i_flow_ctl_enable |-> ##[16:32] !o_txd)
      else $error("driver enable lead above two bits");
   de_hold_a:
      assert property (de && !o_txd |=> de[*8] ##1 de[*8])
      else $error("driver enable dropped inside a frame");
   bit_len_a:
      assert property ($changed(o_txd) |=> $stable(o_txd)[*8] ##1
         $stable(o_txd)[*7])
      else $error("serial bit shorter than sixteen clocks");
   de_on_c: cover property ($rose(de));
   de_off_c: cover property ($fell(de));
   first_c: cover property ($rose(o_rx_stat.frame_first_byte));
   irq_c: cover property ($rose(o_rx_irq));
endmodule
